// ===== logic/vlf_pkg.sv
// Package: register map, reset values and codes for the voltage limit fault response block
package vlf_pkg;
    localparam int unsigned VLF_ADDR_W = 8;
    localparam int unsigned VLF_MEAS_W = 10;

    // Register offsets
    localparam logic [7:0] VLF_UV_CRIT_HI_ADDR = 8'h1C;
    localparam logic [7:0] VLF_UV_CRIT_LO_ADDR = 8'h1D;
    localparam logic [7:0] VLF_OV_WARN_HI_ADDR = 8'h1E;
    localparam logic [7:0] VLF_OV_WARN_LO_ADDR = 8'h1F;
    localparam logic [7:0] VLF_OV_CRIT_HI_ADDR = 8'h20;
    localparam logic [7:0] VLF_OV_CRIT_LO_ADDR = 8'h21;
    localparam logic [7:0] VLF_PG_STATE_ADDR   = 8'h34;

    // Reset values
    localparam logic [7:0] VLF_UV_CRIT_HI_RST = 8'h00;
    localparam logic [1:0] VLF_UV_CRIT_LO_RST = 2'h0;
    localparam logic [7:0] VLF_OV_WARN_HI_RST = 8'hFF;
    localparam logic [1:0] VLF_OV_WARN_LO_RST = 2'h3;
    localparam logic [7:0] VLF_OV_CRIT_HI_RST = 8'hFF;
    localparam logic [1:0] VLF_OV_CRIT_LO_RST = 2'h3;

    // Power-good state register bit positions
    localparam int unsigned VLF_SENSE_BIT = 5;
    localparam int unsigned VLF_ALERT_BIT = 4;
    localparam int unsigned VLF_GOOD_BIT  = 0;

    // Synchroniser depth for pin inputs
    localparam int unsigned VLF_SYNC_STAGES = 3;

    // Fault response codes from the three-state protection input
    typedef enum logic [1:0] {
        VLF_RESP_SHUTDOWN = 2'h0,
        VLF_RESP_ALERT_PG = 2'h1,
        VLF_RESP_ALERT    = 2'h2
    } vlf_resp_t;
endpackage

// ===== logic/vlf_pin_sync.sv
// Pin synchroniser: three stage flops and an output flop per bit, output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module vlf_pin_sync
    import vlf_pkg::*;
#(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync
);
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic [VLF_SYNC_STAGES-1:0] stage_r;

            // Stage 0 feeds only stage 1; filter looks at stages 1 and 2
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    stage_r     <= '0;
                    pin_sync[g] <= 1'b0;
                end else begin
                    stage_r <= {stage_r[VLF_SYNC_STAGES-2:0], pin_in[g]};
                    if (stage_r[1] == stage_r[2]) begin
                        pin_sync[g] <= stage_r[2];
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ===== logic/vlf_limit_resp.sv
// Limit checking, fault response and limit/status registers for the load voltage monitor
//
// Notes on behaviour
// - The protection pin maps low to 00, high to 01, floating to 10, and 10 makes a critical fault raise alert only.
// - With the pin low, a critical under or over violation raises alert, drops power-good and turns the channel off.
// - With the pin high a critical violation raises alert and drops power-good only, and warnings only ever raise alert.
// - The critical undervoltage limit is ten bits, high part at 0x1C and low two bits at 0x1D, both reset to zero.
// - The warning overvoltage limit is ten bits at 0x1E and 0x1F, resetting to 0xFF and 0x03.
// - The critical overvoltage limit is ten bits at 0x20 and 0x21, resetting to full scale.
// - Register 0x34 shows polarity in bit 5 read-only, alert in bit 4 writable and power-good in bit 0 read-only.
// - While power-good holds, a measurement outside the warning limit drives the alert pin low.
// - Power-good is asserted while the voltage sits between the two critical limits; with the pin floating a critical fault leaves it unchanged.
// - The power-good status bit reads 1 when good regardless of polarity, which only flips the pin level.
`timescale 1ns/1ps
`default_nettype none
module vlf_limit_resp
    import vlf_pkg::*;
#(
    parameter int unsigned MEAS_W = VLF_MEAS_W
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    // Register port
    input  wire logic [VLF_ADDR_W-1:0] reg_addr,
    input  wire logic                  reg_wr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    // Latest voltage conversion
    input  wire logic [MEAS_W-1:0]     meas_value,
    input  wire logic                  meas_valid,
    // Pins
    input  wire logic                  prot_pin_level,
    input  wire logic                  prot_pin_float,
    input  wire logic                  output_sense_select,
    output logic                       alert_n,
    output logic                       power_good_output,
    output logic                       channel_on,
    output logic      [1:0]            fault_resp_code
);
    // Limit registers
    logic [7:0]        uv_crit_hi_r;
    logic [1:0]        uv_crit_lo_r;
    logic [7:0]        ov_warn_hi_r;
    logic [1:0]        ov_warn_lo_r;
    logic [7:0]        ov_crit_hi_r;
    logic [1:0]        ov_crit_lo_r;
    // Block state
    logic              good_supply_bit_r;
    logic              alert_r;
    logic              chan_on_r;
    logic [2:0]        pins_sync;
    logic              sense_s;
    vlf_resp_t         resp_nxt;
    vlf_resp_t         resp_r;
    logic [MEAS_W-1:0] undervolt_critical_limit;
    logic [MEAS_W-1:0] overvolt_warning_limit;
    logic [MEAS_W-1:0] overvolt_critical_limit;
    logic              uv_crit_viol;
    logic              ov_crit_viol;
    logic              ov_warn_viol;
    logic              crit_viol;
    logic              alert_event;
    logic              wr_status;

    // Pins come from outside the clock domain
    vlf_pin_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin_in  ({output_sense_select, prot_pin_float, prot_pin_level}),
        .pin_sync(pins_sync)
    );

    assign sense_s = pins_sync[2];

    // Three-state protection pin to response code
    always_comb begin
        if (pins_sync[1]) begin
            resp_nxt = VLF_RESP_ALERT;
        end else if (pins_sync[0]) begin
            resp_nxt = VLF_RESP_ALERT_PG;
        end else begin
            resp_nxt = VLF_RESP_SHUTDOWN;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            resp_r          <= VLF_RESP_ALERT;
            fault_resp_code <= VLF_RESP_ALERT;
        end else begin
            resp_r          <= resp_nxt;
            fault_resp_code <= resp_nxt;
        end
    end

    // Ten-bit limits from register pairs
    assign undervolt_critical_limit = {uv_crit_hi_r, uv_crit_lo_r};
    assign overvolt_warning_limit   = {ov_warn_hi_r, ov_warn_lo_r};
    assign overvolt_critical_limit  = {ov_crit_hi_r, ov_crit_lo_r};

    // Strict compares: a value equal to a limit is not a violation
    assign uv_crit_viol = meas_value < undervolt_critical_limit;
    assign ov_crit_viol = meas_value > overvolt_critical_limit;
    assign ov_warn_viol = meas_value > overvolt_warning_limit;
    assign crit_viol    = uv_crit_viol | ov_crit_viol;

    // Warning only counts while good; critical always raises alert
    assign alert_event = meas_valid & ((good_supply_bit_r & ov_warn_viol) | crit_viol);
    assign wr_status   = reg_wr & (reg_addr == VLF_PG_STATE_ADDR);

    // Limit register writes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            uv_crit_hi_r <= VLF_UV_CRIT_HI_RST;
            uv_crit_lo_r <= VLF_UV_CRIT_LO_RST;
            ov_warn_hi_r <= VLF_OV_WARN_HI_RST;
            ov_warn_lo_r <= VLF_OV_WARN_LO_RST;
            ov_crit_hi_r <= VLF_OV_CRIT_HI_RST;
            ov_crit_lo_r <= VLF_OV_CRIT_LO_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                VLF_UV_CRIT_HI_ADDR: uv_crit_hi_r <= reg_wdata;
                VLF_UV_CRIT_LO_ADDR: uv_crit_lo_r <= reg_wdata[1:0];
                VLF_OV_WARN_HI_ADDR: ov_warn_hi_r <= reg_wdata;
                VLF_OV_WARN_LO_ADDR: ov_warn_lo_r <= reg_wdata[1:0];
                VLF_OV_CRIT_HI_ADDR: ov_crit_hi_r <= reg_wdata;
                VLF_OV_CRIT_LO_ADDR: ov_crit_lo_r <= reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    // Alert is sticky; a new event wins over a software write
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            alert_r <= 1'b0;
        end else if (alert_event) begin
            alert_r <= 1'b1;
        end else if (wr_status) begin
            alert_r <= reg_wdata[VLF_ALERT_BIT];
        end
    end

    // Power-good follows each conversion; floating pin leaves it alone on critical faults
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            good_supply_bit_r <= 1'b0;
        end else if (meas_valid) begin
            if (!crit_viol) begin
                good_supply_bit_r <= 1'b1;
            end else if (resp_r != VLF_RESP_ALERT) begin
                good_supply_bit_r <= 1'b0;
            end
        end
    end

    // Channel shutdown is latched until reset, so a fault cannot chatter the switch
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            chan_on_r <= 1'b1;
        end else if (meas_valid && crit_viol && resp_r == VLF_RESP_SHUTDOWN) begin
            chan_on_r <= 1'b0;
        end
    end

    // Pin outputs, each from a flop
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            alert_n           <= 1'b1;
            power_good_output <= 1'b0;
            channel_on        <= 1'b1;
        end else begin
            alert_n           <= ~(alert_r | alert_event);
            power_good_output <= sense_s ? good_supply_bit_r : ~good_supply_bit_r;
            channel_on        <= chan_on_r & ~(meas_valid & crit_viol & (resp_r == VLF_RESP_SHUTDOWN));
        end
    end

    // Read data, registered one cycle after the read strobe
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                VLF_UV_CRIT_HI_ADDR: reg_rdata <= uv_crit_hi_r;
                VLF_UV_CRIT_LO_ADDR: reg_rdata <= {6'h00, uv_crit_lo_r};
                VLF_OV_WARN_HI_ADDR: reg_rdata <= ov_warn_hi_r;
                VLF_OV_WARN_LO_ADDR: reg_rdata <= {6'h00, ov_warn_lo_r};
                VLF_OV_CRIT_HI_ADDR: reg_rdata <= ov_crit_hi_r;
                VLF_OV_CRIT_LO_ADDR: reg_rdata <= {6'h00, ov_crit_lo_r};
                VLF_PG_STATE_ADDR: begin
                    reg_rdata                <= 8'h00;
                    reg_rdata[VLF_SENSE_BIT] <= sense_s;
                    reg_rdata[VLF_ALERT_BIT] <= alert_r;
                    reg_rdata[VLF_GOOD_BIT]  <= good_supply_bit_r;
                end
                default: reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== test/vlf_limit_resp_asserts.sv
// Port-level checker for the limit and fault response block
`timescale 1ns/1ps
`default_nettype none
module vlf_limit_resp_asserts
    import vlf_pkg::*;
#(
    parameter int unsigned MEAS_W = VLF_MEAS_W
) (
    input wire logic                  ref_clk,
    input wire logic                  rst,
    input wire logic [VLF_ADDR_W-1:0] reg_addr,
    input wire logic                  reg_wr,
    input wire logic [7:0]            reg_wdata,
    input wire logic                  reg_rd,
    input wire logic [7:0]            reg_rdata,
    input wire logic [MEAS_W-1:0]     meas_value,
    input wire logic                  meas_valid,
    input wire logic                  prot_pin_level,
    input wire logic                  prot_pin_float,
    input wire logic                  output_sense_select,
    input wire logic                  alert_n,
    input wire logic                  power_good_output,
    input wire logic                  channel_on,
    input wire logic [1:0]            fault_resp_code
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Pins only trusted once held longer than the synchroniser depth
    sequence float_held; prot_pin_float [*7]; endsequence
    sequence sense_held; $stable(output_sense_select) [*6]; endsequence
    // Status writes that set or clear alert; the alert pin moves one edge after the write, so its change is sampled two edges after it
    wire st_wr  = reg_wr && (reg_addr == 8'h34);
    wire st_set = st_wr && reg_wdata[4];
    wire st_clr = st_wr && !reg_wdata[4];
    float_code_a: assert property (float_held |-> fault_resp_code == 2'h2) else $error("float code wrong");
    shut_latch_a: assert property (!channel_on |=> !channel_on) else $error("channel came back");
    shut_cause_a: assert property ($fell(channel_on) |-> $past(meas_valid) && $past(fault_resp_code) == 2'h0)
        else $error("shutdown without cause");
    shut_pg_a: assert property (sense_held ##0 $fell(channel_on) |=> power_good_output == !output_sense_select)
        else $error("good pin kept on shutdown");
    alert_set_a: assert property ($fell(alert_n) |-> $past(meas_valid) || $past(st_set, 2))
        else $error("alert without cause");
    alert_clr_a: assert property ($rose(alert_n) |-> $past(rst) || $past(st_clr, 2))
        else $error("alert dropped without write");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
    unmapped_a: assert property (reg_rd && !(reg_addr inside {[8'h1C:8'h21], 8'h34}) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    lo_pad_a: assert property (reg_rd && (reg_addr inside {8'h1D, 8'h1F, 8'h21}) |=> reg_rdata[7:2] == 6'h00)
        else $error("low limit pad bits set");
    status_bits_a: assert property (sense_held ##0 reg_rd && reg_addr == 8'h34 |=> reg_rdata[7:6] == 2'h0
        && reg_rdata[3:1] == 3'h0 && reg_rdata[5] == $past(output_sense_select)) else $error("status bits wrong");
endmodule
bind vlf_limit_resp vlf_limit_resp_asserts #(.MEAS_W(MEAS_W)) chk_u (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .meas_value(meas_value), .meas_valid(meas_valid), .prot_pin_level(prot_pin_level),
    .prot_pin_float(prot_pin_float), .output_sense_select(output_sense_select), .alert_n(alert_n),
    .power_good_output(power_good_output), .channel_on(channel_on), .fault_resp_code(fault_resp_code));
`default_nettype wire

// ===== test/vlf_limit_resp_tb.sv
// Self-checking bench for the limit and fault response block
`timescale 1ns/1ps
`default_nettype none
module vlf_limit_resp_tb
    import vlf_pkg::*;
;
    logic       ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, meas_valid = 1'b0;
    logic       prot_pin_level = 1'b1, prot_pin_float = 1'b0, output_sense_select = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [9:0] meas_value = 10'h000;
    logic       alert_n, power_good_output, channel_on;
    logic [1:0] fault_resp_code;
    int         n_mismatch = 0, n_compared = 0, cyc = 0;
    logic [7:0] ra [8] = '{8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h34, 8'h22};
    logic [7:0] rv [8] = '{8'h00, 8'h00, 8'hFF, 8'h03, 8'hFF, 8'h03, 8'h20, 8'h00};
    logic [7:0] wv [8] = '{8'h40, 8'hFF, 8'h80, 8'h00, 8'hC0, 8'h01, 8'hE1, 8'h5A};
    logic [7:0] xv [8] = '{8'h40, 8'h03, 8'h80, 8'h00, 8'hC0, 8'h01, 8'h20, 8'h00};
    // Pins packed as code, alert, channel, good pin for one compare
    wire  [7:0] pins = {3'h0, fault_resp_code, alert_n, channel_on, power_good_output};
    always #25 ref_clk = ~ref_clk;
    vlf_limit_resp dut_u (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_value(meas_value),
        .meas_valid(meas_valid), .prot_pin_level(prot_pin_level), .prot_pin_float(prot_pin_float),
        .output_sense_select(output_sense_select), .alert_n(alert_n), .power_good_output(power_good_output),
        .channel_on(channel_on), .fault_resp_code(fault_resp_code));
    task automatic wrap_up();
        if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard, run needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Strobes wait a falling edge first so none is set twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        chk(reg_rdata, e);
    endtask
    // One sample, pins looked at once the good pin has had its extra cycle
    task automatic ms(input logic [9:0] v, input logic [7:0] e);
        @(negedge ref_clk);
        meas_value = v;
        meas_valid = 1'b1;
        @(negedge ref_clk);
        meas_valid = 1'b0;
        @(negedge ref_clk);
        chk(pins, e);
    endtask
    initial begin
        repeat (5) @(negedge ref_clk);
        rst = 1'b0;
        repeat (8) @(negedge ref_clk);
        chk(pins, 8'h0E);
        foreach (ra[i]) rd(ra[i], rv[i]);
        foreach (ra[i]) begin
            wr(ra[i], wv[i]);
            rd(ra[i], xv[i]);
        end
        ms(10'h180, 8'h0F);
        rd(8'h34, 8'h21);
        ms(10'h200, 8'h0F);
        ms(10'h201, 8'h0B);
        rd(8'h34, 8'h31);
        wr(8'h34, 8'h00);
        // Alert pin rises one edge after the clearing write lands
        @(negedge ref_clk);
        chk(pins, 8'h0F);
        output_sense_select = 1'b0;
        repeat (8) @(negedge ref_clk);
        chk(pins, 8'h0E);
        rd(8'h34, 8'h01);
        // Writing all ones sets alert only; polarity and good bits stay read-only
        wr(8'h34, 8'hFF);
        rd(8'h34, 8'h11);
        wr(8'h34, 8'h00);
        ms(10'h302, 8'h0B);
        rd(8'h34, 8'h10);
        wr(8'h34, 8'h00);
        ms(10'h180, 8'h0E);
        prot_pin_float = 1'b1;
        repeat (8) @(negedge ref_clk);
        ms(10'h103, 8'h16);
        ms(10'h102, 8'h12);
        rd(8'h34, 8'h11);
        wr(8'h34, 8'h00);
        prot_pin_float = 1'b0;
        prot_pin_level = 1'b0;
        repeat (8) @(negedge ref_clk);
        ms(10'h180, 8'h06);
        ms(10'h301, 8'h02);
        wr(8'h34, 8'h00);
        ms(10'h0FF, 8'h01);
        ms(10'h180, 8'h00);
        rst = 1'b1;
        repeat (5) @(negedge ref_clk);
        rst = 1'b0;
        rd(8'h1C, 8'h00);
        repeat (8) @(negedge ref_clk);
        chk(pins, 8'h07);
        wrap_up();
    end
endmodule
`default_nettype wire
